// ==== core/dlcd_pkg.sv ====
// Purpose: Constants for the drive link command decoder
// Assumes: Requests arrive already deframed and checked
// Notes: Codes and limits shared by design and bench
package dlcd_pkg;
  // Instruction codes
  localparam logic [7:0] CodeSetFreqRam = 8'h6D;
  localparam logic [7:0] CodeSetFreqRom = 8'h6E;
  localparam logic [7:0] CodeOutFreq = 8'h6F;
  localparam logic [7:0] CodeOutCurr = 8'h70;
  localparam logic [7:0] CodeOutVolt = 8'h71;
  localparam logic [7:0] CodeSpecMon = 8'h72;
  localparam logic [7:0] CodeMonSelRd = 8'h73;
  localparam logic [7:0] CodeAlarm0 = 8'h74;
  localparam logic [7:0] CodeAlarm3 = 8'h77;
  localparam logic [7:0] CodeStatusExt = 8'h79;
  localparam logic [7:0] CodeStatus = 8'h7A;
  localparam logic [7:0] CodeModeRd = 8'h7B;
  localparam logic [7:0] CodeFreqWr = 8'hED;
  localparam logic [7:0] CodeMonSelWr = 8'hF3;
  localparam logic [7:0] CodeAlarmClr = 8'hF4;
  localparam logic [7:0] CodeRunExt = 8'hF9;
  localparam logic [7:0] CodeRun = 8'hFA;
  localparam logic [7:0] CodeModeWr = 8'hFB;
  localparam logic [7:0] CodeReset = 8'hFD;
  // Data keys and limits
  localparam logic [15:0] KeyNow = 16'h9696;
  localparam logic [15:0] KeyAck = 16'h9966;
  localparam logic [15:0] FreqMax = 16'h9C40;
  localparam logic [15:0] SpeedMax = 16'h270E;
  localparam logic [15:0] ModeMax = 16'h0002;
  localparam logic [7:0] MonSelMin = 8'h01;
  localparam logic [7:0] MonSelMax = 8'h3C;
  localparam logic [7:0] MonSelRst = 8'h01;
  localparam logic [15:0] ModeRst = 16'h0001;
  // Answer codes
  localparam logic [3:0] ErrMode = 4'hA;
  localparam logic [3:0] ErrCode = 4'hB;
  localparam logic [3:0] ErrRange = 4'hC;
  // Check interval in 0.1 s units; 9999 disables supervision
  localparam logic [15:0] ChkOff = 16'd9999;
  localparam logic [15:0] ChkMax = 16'd9998;
  localparam int ClkHz = 125000000;
  localparam int TickMs = 100;
  localparam int TickCycles = ClkHz / 1000 * TickMs;
  localparam int AlarmDepth = 8;
  typedef enum logic [1:0] {DLCD_IDLE, DLCD_ANS, DLCD_RST} dlcd_state_t;
endpackage

// ==== core/drive_link_command_decoder.sv ====
// Purpose: Decode host link requests for the drive and supervise the link
// Assumes: One deframed request at a time, data checked by the framer
// Notes: One clock, synchronous reset; the rules follow
// Overview of operation
// - Answers only host requests, once per request except HFD with H9696
// - Supervision timeout raises the link alarm of the last request's port and stops output
// - External reset input coasts the drive regardless of link state
// - Supervision off means no timeout and the last command stays
// - Mode read H7B, write HFB; 0 network, 1 external, 2 panel
// - H6F returns output frequency, or speed when speed display set; the code always answers outFreq and ignores speedSel
// - H70 returns output current; unit depends on model capacity
// - H71 returns output voltage in 0.1 V steps
// - H72 returns the monitor item chosen by selection number
// - Selection read H73, write HF3, valid H01 to H3C
// - H74..H77 give two alarms each, older high byte, newest H74 low
// - Run command written by HF9 extended and HFA short form
// - Status read by H79 extended and H7A short form
// - Set frequency read from RAM H6D, EEPROM H6E
// - HED writes RAM, accepts up to H9C40, else refused
// - With speed display, writes accept up to H270E
// - HFD with H9696 resets at once, no answer
// - HFD with H9966 answers ACK first, then resets
// - HF4 with H9696 clears whole alarm history
// - Supervision active only for 0.1 s to 999.8 s
// - Unknown code refused with error HB, no alarm
`timescale 1ns/1ps
`default_nettype none
module drive_link_command_decoder
  import dlcd_pkg::*;
#(
  parameter int TICK_CYCLES = TickCycles
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request from link framer
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqCode,
  input wire logic [15:0] reqData,
  input wire logic panelPort,
  // Answer to link framer
  output logic ansValid,
  output logic [15:0] ansData,
  output logic ansErr,
  output logic [3:0] ansErrCode,
  // Drive side
  input wire logic external_reset_input,
  input wire logic speedSel,
  input wire logic [15:0] chkInterval,
  input wire logic [15:0] outFreq,
  input wire logic [15:0] outCurr,
  input wire logic [15:0] outVolt,
  input wire logic [15:0] monData,
  input wire logic [15:0] driveStatus,
  input wire logic [15:0] romFreq,
  input wire logic driveRunning,
  input wire logic alarmPush,
  input wire logic [7:0] alarmCode,
  output logic [7:0] monSel,
  output logic [15:0] runCmd,
  output logic [15:0] setFreq,
  output logic [1:0] opMode,
  output logic outputStop,
  output logic panel_port_link_alarm,
  output logic terminal_link_alarm,
  output logic driveReset
);
  typedef struct packed {
    dlcd_state_t st;
    logic [15:0] ans;
    logic err;
    logic [3:0] errCode;
    logic [15:0] mode;
    logic [7:0] sel;
    logic [15:0] run;
    logic [15:0] freq;
    logic [AlarmDepth*8-1:0] hist;
    logic started;
    logic port;
    logic [31:0] tick;
    logic [15:0] elapsed;
    logic panelAlm;
    logic termAlm;
    logic rstOut;
  } dlcd_regs_t;

  dlcd_regs_t stateReg;
  dlcd_regs_t stateNext;
  logic supOn;
  logic [15:0] freqLimit;
  logic pendAck;
  logic reqTake;

  // Supervision window and range limit
  assign supOn = (chkInterval != 16'h0000) && (chkInterval <= ChkMax);
  assign freqLimit = speedSel ? SpeedMax : FreqMax;

  // Only idle takes a request; finishing takes one cycle
  assign reqReady = (stateReg.st == DLCD_IDLE);
  assign ansValid = (stateReg.st == DLCD_ANS);
  assign reqTake = reqValid && reqReady; // Request taken at this edge
  assign ansData = stateReg.ans;
  assign ansErr = stateReg.err;
  assign ansErrCode = stateReg.errCode;
  assign monSel = stateReg.sel;
  assign runCmd = stateReg.run;
  assign setFreq = stateReg.freq;
  assign opMode = stateReg.mode[1:0];
  assign panel_port_link_alarm = stateReg.panelAlm;
  assign terminal_link_alarm = stateReg.termAlm;
  assign driveReset = stateReg.rstOut;
  // Coast on reset pin works without any link traffic
  assign outputStop = stateReg.panelAlm | stateReg.termAlm | external_reset_input;

  // Next-state logic
  always_comb begin
    stateNext = stateReg;
    stateNext.rstOut = 1'b0;
    case (stateReg.st)
      DLCD_IDLE: begin
        if (reqValid) begin
          stateNext.st = DLCD_ANS;
          stateNext.ans = 16'h0000;
          stateNext.err = 1'b0;
          stateNext.errCode = 4'h0;
          stateNext.started = 1'b1;
          stateNext.port = panelPort;
          stateNext.elapsed = 16'h0000;
          stateNext.tick = 32'h0000_0000;
          case (reqCode)
            CodeModeRd: stateNext.ans = stateReg.mode;
            CodeModeWr: begin
              if (reqData > ModeMax) begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrRange;
              end else if (driveRunning) begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrMode;
              end else begin
                stateNext.mode = reqData;
              end
            end
            CodeOutFreq: stateNext.ans = outFreq;
            CodeOutCurr: stateNext.ans = outCurr;
            CodeOutVolt: stateNext.ans = outVolt;
            CodeSpecMon: stateNext.ans = monData;
            CodeMonSelRd: stateNext.ans = {8'h00, stateReg.sel};
            CodeMonSelWr: begin
              if (reqData[15:8] != 8'h00 || reqData[7:0] < MonSelMin || reqData[7:0] > MonSelMax) begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrRange;
              end else begin
                stateNext.sel = reqData[7:0];
              end
            end
            CodeRunExt: stateNext.run = reqData;
            CodeRun: stateNext.run = {8'h00, reqData[7:0]};
            CodeStatusExt: stateNext.ans = driveStatus;
            CodeStatus: stateNext.ans = {8'h00, driveStatus[7:0]};
            CodeSetFreqRam: stateNext.ans = stateReg.freq;
            CodeSetFreqRom: stateNext.ans = romFreq;
            CodeFreqWr: begin
              if (reqData > freqLimit) begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrRange;
              end else begin
                stateNext.freq = reqData;
              end
            end
            CodeAlarmClr: begin
              if (reqData == KeyNow) begin
                stateNext.hist = '0;
              end else begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrRange;
              end
            end
            CodeReset: begin
              if (reqData == KeyNow) begin
                stateNext.st = DLCD_RST;
              end else if (reqData != KeyAck) begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrRange;
              end
            end
            default: begin
              if (reqCode >= CodeAlarm0 && reqCode <= CodeAlarm3) begin
                stateNext.ans = 16'(stateReg.hist >> (16 * (reqCode - CodeAlarm0)));
              end else begin
                stateNext.err = 1'b1;
                stateNext.errCode = ErrCode;
              end
            end
          endcase
        end
      end
      DLCD_ANS: begin
        // Answer stands one cycle; an acked reset follows below
        stateNext.st = DLCD_IDLE;
      end
      DLCD_RST: begin
        stateNext.st = DLCD_IDLE;
        stateNext.rstOut = 1'b1;
      end
      default: stateNext.st = DLCD_IDLE;
    endcase
    // Ack-then-reset: pulse reset right after the answer cycle
    if (stateReg.st == DLCD_ANS && stateReg.rstOut == 1'b0 && pendAck) begin
      stateNext.rstOut = 1'b1;
    end
    // History shift on new alarm, newest in the low byte
    if (alarmPush) begin
      stateNext.hist = {stateNext.hist[AlarmDepth*8-9:0], alarmCode};
    end
    // External reset clears the link alarms and coasts
    if (external_reset_input) begin
      stateNext.panelAlm = 1'b0;
      stateNext.termAlm = 1'b0;
      stateNext.run = 16'h0000;
      stateNext.started = 1'b0;
    end
    // Timeout set in the same cycle wins over the clear, so no alarm is lost
    // Supervision counter in 0.1 s ticks after first traffic
    if (supOn && stateReg.started && !reqValid) begin
      if (stateReg.tick >= 32'(TICK_CYCLES - 1)) begin
        stateNext.tick = 32'h0000_0000;
        stateNext.elapsed = stateReg.elapsed + 16'h0001;
      end else begin
        stateNext.tick = stateReg.tick + 32'h0000_0001;
      end
      if (stateReg.elapsed >= chkInterval) begin
        if (stateReg.port) begin
          stateNext.panelAlm = 1'b1;
        end else begin
          stateNext.termAlm = 1'b1;
        end
      end
    end
  end

  // Remembers an acknowledged reset request
  logic pendAckReg;
  assign pendAck = pendAckReg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pendAckReg <= 1'b0;
    end else if (stateReg.st == DLCD_IDLE && reqValid) begin
      pendAckReg <= (reqCode == CodeReset) && (reqData == KeyAck);
    end else if (stateReg.st == DLCD_ANS) begin
      pendAckReg <= 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateReg <= '0;
      stateReg.st <= DLCD_IDLE;
      stateReg.mode <= ModeRst;
      stateReg.sel <= MonSelRst;
    end else begin
      stateReg <= stateNext;
    end
  end

  // One answer per request except HFD with H9696, one cycle after it is taken
  AST_ONE_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && !(reqCode == CodeReset && reqData == KeyNow)) |=> ansValid ##1 !ansValid)
    else $error("request not answered once");
  AST_NO_SPONTANEOUS: assert property (@(posedge sys_clk) disable iff (rst)
    ansValid |-> $past(reqValid && reqReady))
    else $error("answer without request");
  AST_RESET_NOW: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && reqCode == CodeReset && reqData == KeyNow) |=> !ansValid ##1 driveReset)
    else $error("immediate reset wrong");
  AST_ACK_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && reqCode == CodeReset && reqData == KeyAck) |=> (ansValid && !ansErr) ##1 driveReset)
    else $error("ack reset wrong");
  AST_BAD_CODE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && reqCode == 8'h00) |=> ansErr && ansErrCode == ErrCode && !$rose(outputStop))
    else $error("unknown code not refused");
  AST_FREQ_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && reqCode == CodeFreqWr && !speedSel && reqData > FreqMax) |=> ansErr && $stable(setFreq))
    else $error("out of range frequency taken");
  AST_CLEAR_HIST: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady && reqCode == CodeAlarmClr && reqData == KeyNow && !alarmPush) |=> stateReg.hist == '0)
    else $error("history not cleared");
  AST_NO_SUPERVISION: assert property (@(posedge sys_clk) disable iff (rst)
    (chkInterval == ChkOff && !panel_port_link_alarm && !terminal_link_alarm) |=> !panel_port_link_alarm && !terminal_link_alarm)
    else $error("alarm with supervision off");
  AST_COAST: assert property (@(posedge sys_clk) disable iff (rst)
    external_reset_input |-> outputStop)
    else $error("no coast on reset input");
  AST_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
    (reqValid && reqReady) |=> !reqReady)
    else $error("request taken while busy");
  // Read answers carry the drive value seen at the take edge
  AST_READ_FREQ: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeOutFreq) |=> ansValid && !ansErr && ansData == $past(outFreq))
    else $error("output frequency answer wrong");
  AST_READ_CURR: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeOutCurr) |=> ansValid && !ansErr && ansData == $past(outCurr))
    else $error("output current answer wrong");
  AST_READ_VOLT: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeOutVolt) |=> ansValid && !ansErr && ansData == $past(outVolt))
    else $error("output voltage answer wrong");
  AST_READ_MON: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeSpecMon) |=> ansValid && !ansErr && ansData == $past(monData))
    else $error("special monitor answer wrong");
  AST_STATUS_SHORT: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeStatus) |=> ansValid && ansData == ($past(driveStatus) & 16'h00FF))
    else $error("short status answer wrong");
  AST_READ_ROM: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeSetFreqRom) |=> ansValid && ansData == $past(romFreq))
    else $error("stored frequency answer wrong");
  AST_READ_MODE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeModeRd) |=> ansValid && ansData == 16'($past(opMode)))
    else $error("mode answer wrong");
  // Accepted writes land, refused ones leave the output alone
  AST_MODE_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeModeWr && reqData <= ModeMax && !driveRunning) |=> 16'(opMode) == $past(reqData))
    else $error("mode write lost");
  AST_SEL_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeMonSelWr && reqData > {8'h00, MonSelMax}) |=> ansErr && $stable(monSel))
    else $error("selection out of range taken");
  AST_RUN_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeRunExt && !external_reset_input) |=> runCmd == $past(reqData))
    else $error("run command write lost");
  AST_SPEED_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    (reqTake && reqCode == CodeFreqWr && speedSel && reqData > SpeedMax) |=> ansErr && $stable(setFreq))
    else $error("out of range speed taken");
  AST_ALARM_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
    alarmPush |=> stateReg.hist[7:0] == $past(alarmCode))
    else $error("new alarm not in low byte");
  // Supervision timeout and reset pulse placement
  AST_TIMEOUT: assert property (@(posedge sys_clk) disable iff (rst)
    (supOn && stateReg.started && !reqValid && stateReg.elapsed >= chkInterval) |=> outputStop)
    else $error("timeout did not stop output");
  AST_RESET_ALONE: assert property (@(posedge sys_clk) disable iff (rst)
    driveReset |-> !ansValid)
    else $error("reset pulse overlaps an answer");
endmodule
`default_nettype wire

// ==== sim/dlcd_host_model.sv ====
// Purpose: Host side of the link, issuing one deframed request at a time
// Assumes: Decoder takes a request on the edge where reqValid and reqReady are high
// Notes: Released code and data lines show the inverse of the last request; panelPort keeps its last value
`timescale 1ns/1ps
`default_nettype none
module dlcd_host_model (
  // Clock
  input wire logic sys_clk,
  // Request toward the decoder
  output var logic reqValid,
  input wire logic reqReady,
  output var logic [7:0] reqCode,
  output var logic [15:0] reqData,
  output var logic panelPort
);
  // Idle until the bench asks for traffic
  initial begin
    reqValid = 1'b0;
    reqCode = 8'h00;
    reqData = 16'h0000;
    panelPort = 1'b0;
  end
  // Only the host starts an exchange; request held until taken or 16 edges pass
  task automatic send(input logic [7:0] c, input logic [15:0] d, input logic p, output bit ok);
    bit rdy;
    ok = 1'b0;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqCode <= c;
    reqData <= d;
    panelPort <= p;
    for (int n = 0; n < 16 && !ok; n++) begin
      // Ready read mid-cycle so the take edge is not raced
      @(negedge sys_clk);
      rdy = (reqReady === 1'b1);
      @(posedge sys_clk);
      ok = rdy;
    end
    reqValid <= 1'b0;
    reqCode <= ~c;
    reqData <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== sim/drive_link_command_decoder_tb_top.sv ====
// Purpose: Self-checking bench for the drive link command decoder
// Assumes: Short supervision tick so timeouts fit a brief run
// Notes: Expected answers queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module drive_link_command_decoder_tb_top;
  import dlcd_pkg::*;
  typedef struct packed {logic cd; logic [15:0] d; logic e; logic [3:0] c;} dlcd_note_t;
  logic sys_clk, rst, reqValid, reqReady, panelPort, ansValid, ansErr, speedSel, driveRunning;
  logic alarmPush, outputStop, panel_port_link_alarm, terminal_link_alarm, driveReset, external_reset_input;
  logic [7:0] reqCode, alarmCode, monSel;
  logic [15:0] reqData, ansData, chkInterval, outFreq, outCurr, outVolt, monData, driveStatus, romFreq;
  logic [15:0] runCmd, setFreq, rc;
  logic [3:0] ansErrCode;
  logic [1:0] opMode;
  int error_cnt, checks, rstExp;
  bit pan;
  dlcd_note_t q[$];
  dlcd_note_t n;
  drive_link_command_decoder #(.TICK_CYCLES(10)) u_drive_link_command_decoder (
    .sys_clk, .rst, .reqValid, .reqReady, .reqCode, .reqData, .panelPort, .ansValid, .ansData,
    .ansErr, .ansErrCode, .external_reset_input, .speedSel, .chkInterval, .outFreq, .outCurr,
    .outVolt, .monData, .driveStatus, .romFreq, .driveRunning, .alarmPush, .alarmCode, .monSel,
    .runCmd, .setFreq, .opMode, .outputStop, .panel_port_link_alarm, .terminal_link_alarm, .driveReset);
  dlcd_host_model u_dlcd_host_model (.sys_clk, .reqValid, .reqReady, .reqCode, .reqData, .panelPort);
  // Free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Queue the expected answer, then hand the request to the host
  task automatic rq(input logic [7:0] c, input logic [15:0] d, input logic cd, input logic [15:0] x,
                    input logic [3:0] ec = 4'h0, input bit ans = 1'b1);
    bit ok;
    if (ans) q.push_back({cd, x, ec != 4'h0, ec});
    u_dlcd_host_model.send(c, d, pan, ok);
    if (!ok) begin
      error_cnt++;
      end_sim();
    end
    repeat (2) @(negedge sys_clk);
  endtask
  // Every answer must match the oldest note; stray answers count as faults
  always @(posedge sys_clk) begin
    if (!rst && ansValid === 1'b1) begin
      if (q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        n = q.pop_front();
        chk(16'(ansErr), 16'(n.e));
        if (n.e) chk(16'(ansErrCode), 16'(n.c));
        if (n.cd) chk(ansData, n.d);
      end
    end
    if (!rst && driveReset === 1'b1) begin
      chk(16'(rstExp > 0 && q.size() == 0), 16'h0001);
      rstExp--;
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    void'($urandom(54652));
    {rst, speedSel, driveRunning, alarmPush, external_reset_input} = 5'b10000;
    {alarmCode, chkInterval} = {8'h00, ChkOff};
    {outFreq, outCurr, outVolt} = {16'($urandom), 16'($urandom), 16'($urandom)};
    {monData, driveStatus, romFreq, rc} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rq(CodeOutFreq, 16'h0000, 1'b1, outFreq);
    rq(CodeOutCurr, 16'h0000, 1'b1, outCurr);
    rq(CodeOutVolt, 16'h0000, 1'b1, outVolt);
    rq(CodeSpecMon, 16'h0000, 1'b1, monData);
    rq(CodeStatusExt, 16'h0000, 1'b1, driveStatus);
    rq(CodeStatus, 16'h0000, 1'b1, {8'h00, driveStatus[7:0]});
    rq(CodeSetFreqRom, 16'h0000, 1'b1, romFreq);
    rq(CodeModeRd, 16'h0000, 1'b1, ModeRst);
    for (int m = 0; m < 3; m++) begin
      rq(CodeModeWr, 16'(m), 1'b0, 16'h0000);
      rq(CodeModeRd, 16'h0000, 1'b1, 16'(m));
      chk(16'(opMode), 16'(m));
    end
    rq(CodeModeWr, 16'h0003, 1'b0, 16'h0000, ErrRange);
    @(posedge sys_clk) driveRunning <= 1'b1;
    rq(CodeModeWr, 16'h0001, 1'b0, 16'h0000, ErrMode);
    @(posedge sys_clk) driveRunning <= 1'b0;
    rq(CodeMonSelRd, 16'h0000, 1'b1, 16'(MonSelRst));
    rq(CodeMonSelWr, 16'(MonSelMax), 1'b0, 16'h0000);
    rq(CodeMonSelRd, 16'h0000, 1'b1, 16'(MonSelMax));
    rq(CodeMonSelWr, 16'h0000, 1'b0, 16'h0000, ErrRange);
    rq(CodeMonSelWr, 16'h003D, 1'b0, 16'h0000, ErrRange);
    chk(16'(monSel), 16'(MonSelMax));
    rq(CodeFreqWr, FreqMax, 1'b0, 16'h0000);
    rq(CodeSetFreqRam, 16'h0000, 1'b1, FreqMax);
    rq(CodeFreqWr, FreqMax + 16'h0001, 1'b0, 16'h0000, ErrRange);
    chk(setFreq, FreqMax);
    @(posedge sys_clk) speedSel <= 1'b1;
    rq(CodeFreqWr, SpeedMax + 16'h0001, 1'b0, 16'h0000, ErrRange);
    rq(CodeFreqWr, SpeedMax, 1'b0, 16'h0000);
    chk(setFreq, SpeedMax);
    @(posedge sys_clk) speedSel <= 1'b0;
    rq(8'h55, 16'h0000, 1'b0, 16'h0000, ErrCode);
    rq(8'h00, 16'h0000, 1'b0, 16'h0000, ErrCode);
    chk(16'({panel_port_link_alarm, terminal_link_alarm, outputStop}), 16'h0000);
    // Nine alarms so the oldest falls out of the eight-deep history
    for (int i = 1; i <= 9; i++) begin
      @(posedge sys_clk) {alarmPush, alarmCode} <= {1'b1, 8'(i)};
      @(posedge sys_clk) alarmPush <= 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      rq(CodeAlarm0 + 8'(i), 16'h0000, 1'b1, {8'(8 - 2 * i), 8'(9 - 2 * i)});
    end
    rq(CodeAlarmClr, 16'h1234, 1'b0, 16'h0000, ErrRange);
    rq(CodeAlarmClr, KeyNow, 1'b0, 16'h0000);
    rq(CodeAlarm0, 16'h0000, 1'b1, 16'h0000);
    rq(CodeAlarm3, 16'h0000, 1'b1, 16'h0000);
    // Supervision per port; interval set before any run command
    for (int p = 1; p >= 0; p--) begin
      pan = p[0];
      @(posedge sys_clk) chkInterval <= 16'd3;
      rq(CodeRunExt, rc, 1'b0, 16'h0000);
      chk(runCmd, rc);
      repeat (15) @(negedge sys_clk);
      chk(16'({panel_port_link_alarm, terminal_link_alarm, outputStop}), 16'h0000);
      repeat (30) @(negedge sys_clk);
      chk(16'({panel_port_link_alarm, terminal_link_alarm, outputStop}), 16'({p[0], !p[0], 1'b1}));
      @(posedge sys_clk) {external_reset_input, chkInterval} <= {1'b1, ChkOff};
      repeat (2) @(negedge sys_clk);
      chk(16'({panel_port_link_alarm, terminal_link_alarm, outputStop}), 16'h0001);
      chk(runCmd, 16'h0000);
      @(posedge sys_clk) external_reset_input <= 1'b0;
    end
    rq(CodeRunExt, ~rc, 1'b0, 16'h0000);
    rq(CodeRun, 16'h0002, 1'b0, 16'h0000);
    repeat (60) @(negedge sys_clk);
    chk(16'({panel_port_link_alarm, terminal_link_alarm, outputStop}), 16'h0000);
    // Mid-run reset returns mode and selection to their defaults
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(16'({opMode, monSel}), {6'h00, ModeRst[1:0], MonSelRst});
    rq(CodeModeRd, 16'h0000, 1'b1, ModeRst);
    rq(CodeReset, 16'h1111, 1'b0, 16'h0000, ErrRange);
    rstExp = 1;
    rq(CodeReset, KeyAck, 1'b0, 16'h0000);
    repeat (3) @(negedge sys_clk);
    rstExp++;
    rq(CodeReset, KeyNow, 1'b0, 16'h0000, 4'h0, 1'b0);
    repeat (4) @(negedge sys_clk);
    chk(16'(rstExp), 16'h0000);
    chk(16'(q.size()), 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
